// >>> common/lipm_pkg.sv
// Package of constants for the indicator and shared interrupt pin multiplexer
package lipm_pkg;
  // Register offsets (word addresses on the plain register port)
  localparam logic [3:0] WAKE_CTRL_ADDR   = 4'h0;
  localparam logic [3:0] PIN_STATUS_ADDR  = 4'h1;
  // Function-select field positions inside the wake control register
  localparam int         ONE_SEL_LSB      = 0;
  localparam int         TWO_SEL_LSB      = 2;
  localparam int         SEL_W            = 2;
  // Function-select codes
  localparam logic [1:0] FSEL_DEFAULT     = 2'h0;
  localparam logic [1:0] FSEL_IRQ         = 2'h1;
  localparam logic [1:0] FSEL_WAKE        = 2'h2;
  localparam logic [1:0] FSEL_LINK_ACT    = 2'h3;
  // Reset values
  localparam logic [3:0] WAKE_CTRL_RESET  = 4'h0;
  // Blink half period of the activity indicator
  localparam int         CLK_MHZ          = 250;
  localparam int         BLINK_HALF_MS    = 50;
  localparam int         BLINK_HALF_CYC   = BLINK_HALF_MS * 1000 * CLK_MHZ;
  // Shared pin modes
  typedef enum logic [0:0] {
    MODE_TX_ERROR = 1'b0,
    MODE_IRQ_OUT  = 1'b1
  } lipm_mode_type;
endpackage

// >>> rtl/lipm_sync3.sv
// Three-stage input synchroniser with agreement check on the last two stages
`timescale 1ns/1ps
module lipm_sync3 #(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Asynchronous input and settled level
  input  wire logic async_in,
  output logic      level_out
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // Stage chain; only the second stage reads the first
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_q <= RESET_VAL;
      s2_q <= RESET_VAL;
      s3_q <= RESET_VAL;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Change accepted only once stages two and three agree
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      level_out <= RESET_VAL;
    end else if (s2_q == s3_q) begin
      level_out <= s3_q;
    end
  end
endmodule

// >>> rtl/lipm_pin_mux.sv
// Indicator and shared interrupt pin function multiplexer
// How it works
// - Latch irq strap at power-on and reset release
// - Irq select has no default; mode comes from the synchronised strap pin level
// - High strap interrupt output, low strap tx-error
// - Each indicator function from own select field
// - Indicator one: on with link, blinks on carrier
// - Indicator two: on at 100 unless isolated, off otherwise
// - Indicator one starts as link/activity after reset
// - Indicator two starts as link speed after reset
// - Indicator two may duplicate the interrupt output
// - Code 11b gives indicator two link/activity
// - Indicator one polarity from regulator strap
// - Indicator two polarity from irq select strap
// - High-strapped pin rests deasserted awaiting wake
// - Code 10b makes indicator a wake output
`timescale 1ns/1ps
module lipm_pin_mux
  import lipm_pkg::*;
#(
  parameter int         BLINK_HALF  = lipm_pkg::BLINK_HALF_CYC,
  parameter logic [1:0] SEL_DEFAULT = lipm_pkg::FSEL_DEFAULT,
  parameter logic [1:0] SEL_IRQ     = lipm_pkg::FSEL_IRQ
) (
  // Clock and reset
  input  wire logic       REF_CLK,
  input  wire logic       RESETN,
  // Register port
  input  wire logic [3:0] REG_ADDR,
  input  wire logic [3:0] REG_WDATA,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  output logic [3:0]      REG_RDATA,
  // Strap pins seen on the shared indicator pins during reset
  input  wire logic       IRQ_PIN_SELECT_STRAP,
  input  wire logic       REGULATOR_OFF_STRAP,
  // Core status
  input  wire logic       LINK_UP,
  input  wire logic       CARRIER_SENSE,
  input  wire logic       SPEED_100,
  input  wire logic       LINE_ISOLATED,
  input  wire logic       IRQ_ACTIVE,
  input  wire logic       WAKE_ACTIVE,
  // Shared interrupt / transmit-error pin
  input  wire logic       SHARED_PIN_IN,
  output logic            IRQ_REQUEST_LOW_O,
  output logic            IRQ_REQUEST_LOW_OE,
  output logic            TX_ERROR_INPUT,
  output logic            TX_SYMBOL_BIT_FOUR,
  // Indicator pins
  output logic            INDICATOR_ONE,
  output logic            INDICATOR_TWO,
  output logic            SHARED_PIN_MODE
);
  import lipm_pkg::*;

  localparam int BW = $clog2(BLINK_HALF + 1);

  logic          irq_strap_s;
  logic          reg_strap_s;
  logic          shared_in_s;
  logic          resetn_d1_q;
  logic          strap_take;
  lipm_mode_type mode_q;
  logic          one_pol_low_q;
  logic [1:0]    one_sel_q;
  logic [1:0]    two_sel_q;
  logic [BW-1:0] blink_cnt_q;
  logic          blink_q;
  logic          link_act;
  logic          one_act;
  logic          two_act;

  // Strap pins are asynchronous to the transceiver clock
  lipm_sync3 #(.RESET_VAL(1'b1)) u_sync_irqsel (
    .clk       (REF_CLK),
    .rst_n     (1'b1),
    .async_in  (IRQ_PIN_SELECT_STRAP),
    .level_out (irq_strap_s)
  );
  lipm_sync3 #(.RESET_VAL(1'b0)) u_sync_regulator_off_strap (
    .clk       (REF_CLK),
    .rst_n     (1'b1),
    .async_in  (REGULATOR_OFF_STRAP),
    .level_out (reg_strap_s)
  );
  lipm_sync3 #(.RESET_VAL(1'b0)) u_sync_shared (
    .clk       (REF_CLK),
    .rst_n     (RESETN),
    .async_in  (SHARED_PIN_IN),
    .level_out (shared_in_s)
  );

  // Remember reset to find its release edge; only a low-to-high change of RESETN counts as a release
  always_ff @(posedge REF_CLK) begin
    resetn_d1_q <= RESETN;
  end
  assign strap_take = !RESETN;

  // Straps track the pins while reset is held, so the value at release is kept
  always_ff @(posedge REF_CLK) begin
    if (strap_take) begin
      mode_q        <= lipm_mode_type'(irq_strap_s);
      one_pol_low_q <= reg_strap_s;
    end
  end

  // Wake control register: function selects, default link functions
  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      one_sel_q <= SEL_DEFAULT;
      two_sel_q <= SEL_DEFAULT;
    end else if (REG_WR && REG_ADDR == WAKE_CTRL_ADDR) begin
      one_sel_q <= REG_WDATA[ONE_SEL_LSB +: SEL_W];
      two_sel_q <= REG_WDATA[TWO_SEL_LSB +: SEL_W];
    end
  end

  // Read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      REG_RDATA <= 4'h0;
    end else if (REG_RD) begin
      case (REG_ADDR)
        WAKE_CTRL_ADDR:  REG_RDATA <= {two_sel_q, one_sel_q};
        PIN_STATUS_ADDR: REG_RDATA <= {1'b0, one_pol_low_q, irq_strap_s, mode_q};
        default:         REG_RDATA <= 4'h0;
      endcase
    end else begin
      REG_RDATA <= 4'h0;
    end
  end

  // Blink divider runs only with carrier so the lamp restarts lit
  always_ff @(posedge REF_CLK) begin
    if (!RESETN || !CARRIER_SENSE) begin
      blink_cnt_q <= '0;
      blink_q     <= 1'b0;
    end else if (blink_cnt_q == BW'(BLINK_HALF - 1)) begin
      blink_cnt_q <= '0;
      blink_q     <= !blink_q;
    end else begin
      blink_cnt_q <= blink_cnt_q + 1'b1;
    end
  end

  // Link/activity: steady with link, toggled while carrier is up
  assign link_act = LINK_UP && !(CARRIER_SENSE && blink_q);

  // Function choice per indicator; interrupt and wake are asserted-active
  always_comb begin
    case (one_sel_q)
      FSEL_WAKE:   one_act = WAKE_ACTIVE;
      SEL_IRQ:     one_act = IRQ_ACTIVE;
      default:     one_act = link_act;
    endcase
    case (two_sel_q)
      FSEL_WAKE:     two_act = WAKE_ACTIVE;
      SEL_IRQ:       two_act = IRQ_ACTIVE;
      FSEL_LINK_ACT: two_act = link_act;
      default:       two_act = SPEED_100 && !LINE_ISOLATED;
    endcase
  end

  // Pin drive with strap polarity; idle level is the inactive level
  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      INDICATOR_ONE <= 1'b0;
      INDICATOR_TWO <= 1'b0;
    end else begin
      INDICATOR_ONE <= one_act ^ one_pol_low_q;
      INDICATOR_TWO <= two_act ^ mode_q;
    end
  end

  // Shared pin: driven low on interrupt and high otherwise in interrupt mode, input in tx-error mode
  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      IRQ_REQUEST_LOW_O  <= 1'b1;
      IRQ_REQUEST_LOW_OE <= 1'b0;
      TX_ERROR_INPUT     <= 1'b0;
      TX_SYMBOL_BIT_FOUR <= 1'b0;
      SHARED_PIN_MODE    <= 1'b1;
    end else begin
      SHARED_PIN_MODE    <= mode_q;
      IRQ_REQUEST_LOW_O  <= !IRQ_ACTIVE;
      IRQ_REQUEST_LOW_OE <= (mode_q == MODE_IRQ_OUT);
      TX_ERROR_INPUT     <= (mode_q == MODE_TX_ERROR) && shared_in_s;
      TX_SYMBOL_BIT_FOUR <= (mode_q == MODE_TX_ERROR) && shared_in_s;
    end
  end

  // Checks: named steps, three of them shared by two properties each
  sequence s_release;
    !$past(RESETN) && RESETN;
  endsequence
  sequence s_rst_edge;
    !resetn_d1_q && RESETN;
  endsequence
  sequence s_ctrl_write;
    REG_WR && REG_ADDR == WAKE_CTRL_ADDR;
  endsequence
  sequence s_ctrl_read;
    REG_RD && REG_ADDR == WAKE_CTRL_ADDR;
  endsequence
  sequence s_status_read;
    REG_RD && REG_ADDR == PIN_STATUS_ADDR;
  endsequence
  sequence s_two_irq_held;
    two_sel_q == SEL_IRQ ##1 two_sel_q == SEL_IRQ;
  endsequence
  sequence s_one_wake_held;
    one_sel_q == FSEL_WAKE ##1 one_sel_q == FSEL_WAKE;
  endsequence
  sequence s_blink_wrap;
    CARRIER_SENSE && blink_cnt_q == BW'(BLINK_HALF - 1);
  endsequence

  // Strap capture; the first cycle after release is skipped as it still sees the last capture
  chk_strap_hold: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    resetn_d1_q |-> $stable(mode_q))
    else $error("mode changed outside reset");
  // Mode after release is the strap level seen in the last reset cycle
  chk_mode_capture: assert property (@(posedge REF_CLK)
    s_rst_edge |-> mode_q == lipm_mode_type'($past(irq_strap_s)))
    else $error("mode not captured");
  // Indicator one polarity captured like the mode
  chk_pol_capture: assert property (@(posedge REF_CLK)
    s_rst_edge |-> one_pol_low_q == $past(reg_strap_s))
    else $error("polarity not captured");
  // Polarity is frozen outside reset
  chk_pol_hold: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    resetn_d1_q |-> $stable(one_pol_low_q))
    else $error("polarity changed outside reset");
  // Mode reaches its pin one cycle after release
  chk_default_mode: assert property (@(posedge REF_CLK)
    s_release |-> ##1 SHARED_PIN_MODE == mode_q)
    else $error("mode not shown");
  // Mode pin tracks the held mode
  chk_mode_shown: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    RESETN |=> SHARED_PIN_MODE == $past(mode_q))
    else $error("mode pin stale");
  // Reset levels of the pins: both indicators low, interrupt mode, no drive
  chk_reset_pins: assert property (@(posedge REF_CLK)
    !RESETN |=> !INDICATOR_ONE && !INDICATOR_TWO && SHARED_PIN_MODE && !IRQ_REQUEST_LOW_OE)
    else $error("reset pin levels");

  // Shared pin never driven in tx-error mode
  chk_irq_drive: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    mode_q == MODE_TX_ERROR |=> !IRQ_REQUEST_LOW_OE)
    else $error("drove in tx mode");
  // Shared pin driven in interrupt mode
  chk_irq_enable: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    mode_q == MODE_IRQ_OUT |=> IRQ_REQUEST_LOW_OE)
    else $error("no drive in irq mode");
  // Interrupt pulls the pin low
  chk_irq_level: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    IRQ_ACTIVE |=> !IRQ_REQUEST_LOW_O)
    else $error("irq not low");
  // No interrupt leaves the pin high
  chk_irq_idle: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    !IRQ_ACTIVE |=> IRQ_REQUEST_LOW_O)
    else $error("irq idle not high");
  // Transmit error inputs are quiet in interrupt mode
  chk_tx_gate: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    mode_q == MODE_IRQ_OUT |=> !TX_ERROR_INPUT && !TX_SYMBOL_BIT_FOUR)
    else $error("tx input leaked");
  // Transmit error follows the settled pin in tx-error mode
  chk_tx_follow: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    mode_q == MODE_TX_ERROR |=> TX_ERROR_INPUT == $past(shared_in_s))
    else $error("tx input stale");

  // Select fields stored from a control write
  chk_sel_write: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    s_ctrl_write |=> one_sel_q == $past(REG_WDATA[1:0]))
    else $error("select one not stored");
  chk_two_write: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    s_ctrl_write |=> two_sel_q == $past(REG_WDATA[3:2]))
    else $error("select two not stored");
  // Selects only move on a control write
  chk_sel_hold: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    !(REG_WR && REG_ADDR == WAKE_CTRL_ADDR) |=> $stable(one_sel_q) && $stable(two_sel_q))
    else $error("select moved");
  // Control read returns both fields
  chk_ctrl_read: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    s_ctrl_read |=> REG_RDATA == {$past(two_sel_q), $past(one_sel_q)})
    else $error("control read");
  // Status read shows the held mode in bit zero
  chk_status_read: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    s_status_read |=> REG_RDATA[0] == $past(mode_q))
    else $error("status read");
  // Read data stand only after a read
  chk_rdata_idle: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    !REG_RD |=> REG_RDATA == 4'h0)
    else $error("read data not idle");
  // Both selects back to default at release
  chk_reset_sel: assert property (@(posedge REF_CLK)
    s_release |-> one_sel_q == SEL_DEFAULT && two_sel_q == SEL_DEFAULT)
    else $error("select not default");

  // Link lamp lit with link and no carrier
  chk_one_link: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    one_sel_q == SEL_DEFAULT && LINK_UP && !CARRIER_SENSE |=> INDICATOR_ONE == !one_pol_low_q)
    else $error("link lamp off");
  // Link lamp dark without link
  chk_one_dark: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    one_sel_q == SEL_DEFAULT && !LINK_UP |=> INDICATOR_ONE == one_pol_low_q)
    else $error("link lamp lit");
  // Blink phase flips at each divider wrap
  chk_blink_toggle: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    s_blink_wrap |=> blink_q != $past(blink_q))
    else $error("blink did not flip");
  // Divider rests while carrier is low, so activity starts lit
  chk_blink_rest: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    !CARRIER_SENSE |=> !blink_q && blink_cnt_q == '0)
    else $error("blink not at rest");
  // Speed lamp dark at 10
  chk_two_speed: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    two_sel_q == SEL_DEFAULT && !SPEED_100 |=> INDICATOR_TWO == mode_q)
    else $error("speed lamp on at 10");
  // Speed lamp lit at 100 unless isolated
  chk_two_fast: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    two_sel_q == SEL_DEFAULT && SPEED_100 && !LINE_ISOLATED |=> INDICATOR_TWO == !mode_q)
    else $error("speed lamp off at 100");
  // Speed lamp dark while isolated
  chk_two_isolated: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    two_sel_q == SEL_DEFAULT && LINE_ISOLATED |=> INDICATOR_TWO == mode_q)
    else $error("speed lamp on isolated");
  // Code 11b moves link/activity onto indicator two
  chk_two_linkact: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    two_sel_q == FSEL_LINK_ACT && LINK_UP && !CARRIER_SENSE |=> INDICATOR_TWO == !mode_q)
    else $error("link on two off");

  // Interrupt duplicated on indicator two
  chk_two_irq: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    s_two_irq_held |-> INDICATOR_TWO == ($past(IRQ_ACTIVE) ^ mode_q))
    else $error("irq not on two");
  // Interrupt on indicator one
  chk_one_irq: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    one_sel_q == SEL_IRQ && IRQ_ACTIVE |=> INDICATOR_ONE == !one_pol_low_q)
    else $error("irq not on one");
  // Wake output on indicator one rests deasserted
  chk_wake_one: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    one_sel_q == FSEL_WAKE && !WAKE_ACTIVE |=> INDICATOR_ONE == one_pol_low_q)
    else $error("wake idle level");
  // Wake output on indicator one follows the event
  chk_wake_one_on: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    s_one_wake_held |-> INDICATOR_ONE == ($past(WAKE_ACTIVE) ^ one_pol_low_q))
    else $error("wake not on one");
  // Wake output on indicator two rests deasserted
  chk_wake_two: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    two_sel_q == FSEL_WAKE && !WAKE_ACTIVE |=> INDICATOR_TWO == mode_q)
    else $error("wake two idle level");
endmodule

// >>> dv/lipm_host_model.sv
// Host side model: shared pin wire with pull-up, MAC error drive, lamp on indicator one
`timescale 1ns/1ps
module lipm_host_model (
  // Device side of the shared pin
  input  wire logic irq_o,
  input  wire logic irq_oe,
  // MAC transmit error drive
  input  wire logic mac_en,
  input  wire logic mac_err,
  // Indicator one and its strap
  input  wire logic ind_one,
  input  wire logic regulator_off_strap,
  // Resolved levels
  output logic      shared_wire,
  output logic      lamp_one_lit
);
  // Pull-up wins when nobody drives; MAC drives only in tx-error strapping
  assign shared_wire = irq_oe ? irq_o : (mac_en ? mac_err : 1'b1);
  // No lamp fitted on a low-strapped indicator one, it would glow awaiting wake
  assign lamp_one_lit = regulator_off_strap ? ~ind_one : 1'b0;
endmodule

// >>> dv/lipm_pin_mux_test.sv
// Directed testbench for the indicator and shared pin multiplexer
`timescale 1ns/1ps
module lipm_pin_mux_test;
  import lipm_pkg::*;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [3:0] wdata = 4'h0;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [3:0] rdata;
  logic       irqsel = 1'b1;
  logic       regulator_off_strap = 1'b0;
  logic       link = 1'b0, crs = 1'b0, spd = 1'b0, iso = 1'b0, irqa = 1'b0, wka = 1'b0;
  logic       mac_en = 1'b0, mac_err = 1'b0;
  logic       pin_in, irq_o, irq_oe, txe, tx_symbol_bit_four, ind1, ind2, mode, lamp;
  int         err_total = 0;
  int         n_checks = 0;
  int         n;
  logic       prev;

  lipm_pin_mux #(.BLINK_HALF(4)) u_lipm_pin_mux (
    .REF_CLK(clk), .RESETN(rst_n), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
    .REG_RD(rd), .REG_RDATA(rdata), .IRQ_PIN_SELECT_STRAP(irqsel),
    .REGULATOR_OFF_STRAP(regulator_off_strap), .LINK_UP(link), .CARRIER_SENSE(crs),
    .SPEED_100(spd), .LINE_ISOLATED(iso), .IRQ_ACTIVE(irqa), .WAKE_ACTIVE(wka),
    .SHARED_PIN_IN(pin_in), .IRQ_REQUEST_LOW_O(irq_o), .IRQ_REQUEST_LOW_OE(irq_oe),
    .TX_ERROR_INPUT(txe), .TX_SYMBOL_BIT_FOUR(tx_symbol_bit_four), .INDICATOR_ONE(ind1),
    .INDICATOR_TWO(ind2), .SHARED_PIN_MODE(mode));

  lipm_host_model u_lipm_host_model (
    .irq_o(irq_o), .irq_oe(irq_oe), .mac_en(mac_en), .mac_err(mac_err),
    .ind_one(ind1), .regulator_off_strap(regulator_off_strap), .shared_wire(pin_in), .lamp_one_lit(lamp));

  // Free-running reference clock
  initial begin
    forever #2 clk = ~clk;
  end

  task step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task chk(input string nm, input logic [3:0] seen, input logic [3:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task wr_reg(input logic [3:0] a, input logic [3:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    step(3);
  endtask

  task rd_reg(input logic [3:0] a, input logic [3:0] e);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("rdata", rdata, e);
  endtask

  // Status inputs change on the edge, checks after the pins settle
  task st(input logic l, input logic c, input logic s, input logic i, input logic q,
          input logic w);
    @(posedge clk);
    link <= l; crs <= c; spd <= s; iso <= i; irqa <= q; wka <= w;
    step(4);
  endtask

  // Reset long enough for the straps to cross the synchroniser
  task do_reset(input logic isel, input logic roff);
    @(posedge clk);
    rst_n <= 1'b0; irqsel <= isel; regulator_off_strap <= roff;
    step(8);
    rst_n <= 1'b1;
    step(1);
  endtask

  task test_done;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Watchdog: a hang counts as a mismatch
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    test_done;
  end

  initial begin
    do_reset(1'b1, 1'b0);
    chk("mode", mode, 4'h1);
    chk("oe", irq_oe, 4'h1);
    rd_reg(PIN_STATUS_ADDR, 4'h3);
    st(1, 0, 1, 0, 1, 0);
    chk("irq", irq_o, 4'h0);
    chk("txe", txe, 4'h0);
    chk("ind1", ind1, 4'h1);
    chk("ind2", ind2, 4'h0);
    st(1, 0, 0, 0, 0, 0);
    chk("ind2", ind2, 4'h1);
    st(1, 0, 1, 1, 0, 0);
    chk("ind2", ind2, 4'h1);
    // Activity blinks the lamp; count edges over a bounded window
    st(1, 1, 1, 0, 0, 0);
    n = 0;
    prev = ind1;
    repeat (24) begin
      step(1);
      if (ind1 !== prev) n++;
      prev = ind1;
    end
    chk("blink", 4'(n >= 2), 4'h1);
    st(1, 0, 1, 0, 1, 0);
    wr_reg(WAKE_CTRL_ADDR, {FSEL_IRQ, FSEL_WAKE});
    rd_reg(WAKE_CTRL_ADDR, {FSEL_IRQ, FSEL_WAKE});
    chk("ind2", ind2, 4'h0);
    chk("ind1", ind1, 4'h0);
    st(1, 0, 1, 0, 0, 1);
    chk("ind2", ind2, 4'h1);
    chk("ind1", ind1, 4'h1);
    wr_reg(WAKE_CTRL_ADDR, {FSEL_WAKE, FSEL_LINK_ACT});
    chk("ind2", ind2, 4'h0);
    st(1, 0, 1, 0, 0, 0);
    chk("ind2", ind2, 4'h1);
    wr_reg(WAKE_CTRL_ADDR, {FSEL_LINK_ACT, FSEL_DEFAULT});
    st(1, 0, 0, 0, 0, 0);
    chk("ind2", ind2, 4'h0);
    wr_reg(4'h5, 4'hF);
    rd_reg(4'h5, 4'h0);
    // Second reset with straps flipped: tx-error mode, polarities swap
    do_reset(1'b0, 1'b1);
    rd_reg(WAKE_CTRL_ADDR, WAKE_CTRL_RESET);
    chk("mode", mode, 4'h0);
    chk("oe", irq_oe, 4'h0);
    rd_reg(PIN_STATUS_ADDR, 4'h4);
    @(posedge clk);
    mac_en <= 1'b1; mac_err <= 1'b1;
    st(1, 0, 1, 0, 1, 0);
    chk("txe", txe, 4'h1);
    chk("tx_symbol_bit_four", tx_symbol_bit_four, 4'h1);
    chk("ind1", ind1, 4'h0);
    chk("lamp", lamp, 4'h1);
    chk("ind2", ind2, 4'h1);
    @(posedge clk);
    mac_err <= 1'b0;
    step(6);
    chk("txe", txe, 4'h0);
    test_done;
  end
endmodule
